// ### rtl/crf_pkg.sv
// crf_pkg: constants for the cpu register file and condition flags
// assumes: used by crf_core and the testbench, every use written crf_pkg::name
package crf_pkg;
  localparam logic [15:0] SP_RESET      = 16'h00FF;
  localparam logic [7:0]  SP_LOW_RESET  = 8'hFF;
  localparam logic [15:0] VEC_RESET     = 16'hFFFE;
  localparam logic [15:0] VEC_SWI       = 16'hFFFC;
  localparam logic [15:0] VEC_SWI_MON   = 16'hFEFC;
  // flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;
  localparam int FLG_H = 4;
  localparam int FLG_V = 7;
  localparam logic [7:0]  FLAGS_FIXED   = 8'h60;
  localparam logic [7:0]  FLAGS_RESET   = 8'h68;
  // oscillator stabilization delay after stop wake-up
  localparam int          OSC_STAB_NS   = 32;
  localparam int          CLK_NS        = 8;
  localparam int          OSC_STAB_CYC  = (OSC_STAB_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] OSC_STAB_CNT  = 16'(OSC_STAB_CYC);
  // register port addresses
  localparam logic [2:0]  ADR_ACC       = 3'h0;
  localparam logic [2:0]  ADR_IDX_LO    = 3'h1;
  localparam logic [2:0]  ADR_IDX_HI    = 3'h2;
  localparam logic [2:0]  ADR_SP_LO     = 3'h3;
  localparam logic [2:0]  ADR_SP_HI     = 3'h4;
  localparam logic [2:0]  ADR_PC_LO     = 3'h5;
  localparam logic [2:0]  ADR_PC_HI     = 3'h6;
  localparam logic [2:0]  ADR_FLAGS     = 3'h7;
  // alu operations
  typedef enum logic [3:0] {
    CRF_OP_NONE = 4'h0,
    CRF_OP_ADD  = 4'h1,
    CRF_OP_ADC  = 4'h2,
    CRF_OP_SUB  = 4'h3,
    CRF_OP_AND  = 4'h4,
    CRF_OP_OR   = 4'h5,
    CRF_OP_EOR  = 4'h6,
    CRF_OP_LDA  = 4'h7,
    CRF_OP_ASL  = 4'h8,
    CRF_OP_LSR  = 4'h9,
    CRF_OP_ROL  = 4'hA,
    CRF_OP_ROR  = 4'hB,
    CRF_OP_DAA  = 4'hC
  } crf_alu_e;
  // low-power / interrupt state
  typedef enum logic [2:0] {
    CRF_ST_RUN   = 3'b000,
    CRF_ST_WAIT  = 3'b001,
    CRF_ST_STOP  = 3'b010,
    CRF_ST_STAB  = 3'b011,
    CRF_ST_STACK = 3'b100,
    CRF_ST_VEC   = 3'b101
  } crf_state_e;
endpackage : crf_pkg

// ### rtl/crf_core.sv
// crf_core: programmer-visible registers, flags, interrupt mask, low-power and break
// assumes: sequencer drives one-cycle strobes; memory returns vector words on vec_data
//
// Operation
// - 8-bit accumulator holds operands and takes alu results
// - 16-bit index pair from high and low bytes forms indexed addresses
// - reset loads stack pointer with 00FF
// - reset-stack-low instruction sets low byte FF, keeps high byte
// - stack pointer decrements on push, increments on pull
// - program pointer increments per fetch, loads on jump, branch, interrupt
// - leaving reset loads program pointer from vector at FFFE/FFFF
// - flags register 8 bits, bits 6 and 5 always read one
// - overflow flag shows two's complement overflow
// - half carry set on carry from bit 3 into bit 4 on adds
// - mask set blocks maskable interrupts, clear accepts them
// - interrupt entry stacks registers, then sets mask, then fetches vector
// - interrupt entry never stacks the index high byte
// - after mask clears, highest priority pending request served first
// - return from interrupt restores stacked registers including mask
// - reset sets mask; clear-mask, return, low-power and a flags port write clear it
// - negative flag equals result bit 7
// - carry from bit 7 on add, borrow on subtract, shifts update it
// - wait clears mask, stops clock; irq wake runs interrupt entry, which sets mask
// - stop clears mask, stops clock; clock restarts after stabilization delay
// - enabled break runs software interrupt after instruction, vector per mode
// - return in break handler ends break once request deasserted
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ns
module crf_core (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // alu
  input  wire crf_pkg::crf_alu_e alu_op,
  input  wire logic [7:0]  alu_operand,
  // sequencer strobes
  input  wire logic        fetch,
  input  wire logic        jump,
  input  wire logic [15:0] jump_addr,
  input  wire logic        push,
  input  wire logic        pull,
  input  wire logic        reset_stack_low_instr,
  input  wire logic        clear_mask_instr,
  input  wire logic        set_mask_instr,
  input  wire logic        return_from_irq_instr,
  input  wire logic [7:0]  stacked_flags,
  input  wire logic        wait_instr,
  input  wire logic        stop_instr,
  input  wire logic        instr_done,
  input  wire logic        stack_done,
  // interrupts and break
  input  wire logic [7:0]  irq_req,
  input  wire logic [15:0] irq_vec_addr [8],
  input  wire logic        brk_enable,
  input  wire logic        brk_req,
  input  wire logic        monitor_mode,
  // vector fetch
  input  wire logic        vec_valid,
  input  wire logic [15:0] vec_data,
  // outputs
  output logic      [15:0] index_addr,
  output logic      [15:0] stack_ptr,
  output logic      [15:0] instr_pointer,
  output logic      [7:0]  condition_flags,
  output logic             cpu_clk_en,
  output logic             irq_stack_req,
  output logic             vec_fetch_req,
  output logic      [15:0] vec_fetch_addr,
  output logic             in_break
);

////////////////////////////////////////////////////////////////////////////
logic [7:0]          acc_reg;
logic [15:0]         idx_reg;
logic [15:0]         sp_reg;
logic [15:0]         pc_reg;
logic [7:0]          flags_reg;
logic                pc_boot_reg;
logic [15:0]         stab_reg;
logic [2:0]          irq_sel;
logic                irq_any;
logic                brk_take;
crf_pkg::crf_state_e state_reg;
logic [8:0]          sum;
logic [4:0]          half_sum;
logic [7:0]          res;
logic                res_c;
logic                res_v;
logic                alu_act;
logic                mask;

assign mask = flags_reg[crf_pkg::FLG_I];

////////////////////////////////////////////////////////////////////////////
// alu result and flags
always_comb begin
  sum      = 9'h000;
  half_sum = 5'h00;
  res      = acc_reg;
  res_c    = flags_reg[crf_pkg::FLG_C];
  res_v    = 1'b0;
  alu_act  = 1'b1;
  case (alu_op)
    crf_pkg::CRF_OP_ADD, crf_pkg::CRF_OP_ADC: begin
      sum = {1'b0, acc_reg} + {1'b0, alu_operand}
          + {8'h00, alu_op == crf_pkg::CRF_OP_ADC && flags_reg[crf_pkg::FLG_C]};
      half_sum = {1'b0, acc_reg[3:0]} + {1'b0, alu_operand[3:0]}
          + {4'h0, alu_op == crf_pkg::CRF_OP_ADC && flags_reg[crf_pkg::FLG_C]};
      res   = sum[7:0];
      res_c = sum[8];
      res_v = (acc_reg[7] == alu_operand[7]) && (res[7] != acc_reg[7]);
    end
    crf_pkg::CRF_OP_SUB: begin
      sum   = {1'b0, acc_reg} - {1'b0, alu_operand};
      res   = sum[7:0];
      res_c = sum[8];
      res_v = (acc_reg[7] != alu_operand[7]) && (res[7] != acc_reg[7]);
    end
    crf_pkg::CRF_OP_AND: res = acc_reg & alu_operand;
    crf_pkg::CRF_OP_OR:  res = acc_reg | alu_operand;
    crf_pkg::CRF_OP_EOR: res = acc_reg ^ alu_operand;
    crf_pkg::CRF_OP_LDA: res = alu_operand;
    crf_pkg::CRF_OP_ASL: begin
      res   = {acc_reg[6:0], 1'b0};
      res_c = acc_reg[7];
      res_v = acc_reg[7] ^ acc_reg[6];
    end
    crf_pkg::CRF_OP_LSR: begin
      res   = {1'b0, acc_reg[7:1]};
      res_c = acc_reg[0];
      res_v = acc_reg[0];
    end
    crf_pkg::CRF_OP_ROL: begin
      res   = {acc_reg[6:0], flags_reg[crf_pkg::FLG_C]};
      res_c = acc_reg[7];
      res_v = acc_reg[7] ^ acc_reg[6];
    end
    crf_pkg::CRF_OP_ROR: begin
      res   = {flags_reg[crf_pkg::FLG_C], acc_reg[7:1]};
      res_c = acc_reg[0];
      res_v = flags_reg[crf_pkg::FLG_C] ^ acc_reg[0];
    end
    crf_pkg::CRF_OP_DAA: begin
      // decimal correction from half carry and carry
      res = acc_reg;
      if (flags_reg[crf_pkg::FLG_H] || acc_reg[3:0] > 4'h9) res = res + 8'h06;
      if (flags_reg[crf_pkg::FLG_C] || acc_reg > 8'h99) begin
        res   = res + 8'h60;
        res_c = 1'b1;
      end
      res_v = flags_reg[crf_pkg::FLG_V];
    end
    default: alu_act = 1'b0;
  endcase
end

////////////////////////////////////////////////////////////////////////////
// accumulator and index pair
always_ff @(posedge mclk) begin
  if (!rstn) begin
    acc_reg <= 8'h00;
  end else if (reg_wr && reg_addr == crf_pkg::ADR_ACC) begin
    acc_reg <= reg_wdata;
  end else if (alu_act) begin
    acc_reg <= res;
  end
end

always_ff @(posedge mclk) begin
  if (!rstn) begin
    idx_reg <= 16'h0000;
  end else if (reg_wr && reg_addr == crf_pkg::ADR_IDX_LO) begin
    idx_reg[7:0] <= reg_wdata;
  end else if (reg_wr && reg_addr == crf_pkg::ADR_IDX_HI) begin
    idx_reg[15:8] <= reg_wdata;
  end
end

////////////////////////////////////////////////////////////////////////////
// stack pointer; interrupt stacking is done by sequencer push strobes
always_ff @(posedge mclk) begin
  if (!rstn) begin
    sp_reg <= crf_pkg::SP_RESET;
  end else if (reset_stack_low_instr) begin
    sp_reg[7:0] <= crf_pkg::SP_LOW_RESET;
  end else if (reg_wr && reg_addr == crf_pkg::ADR_SP_LO) begin
    sp_reg[7:0] <= reg_wdata;
  end else if (reg_wr && reg_addr == crf_pkg::ADR_SP_HI) begin
    sp_reg[15:8] <= reg_wdata;
  end else if (push) begin
    sp_reg <= sp_reg - 16'h0001;
  end else if (pull) begin
    sp_reg <= sp_reg + 16'h0001;
  end
end

////////////////////////////////////////////////////////////////////////////
// interrupt arbitration: lowest index is highest priority
always_comb begin
  irq_sel = 3'h0;
  irq_any = 1'b0;
  for (int i = 7; i >= 0; i--) begin
    if (irq_req[i]) begin
      irq_sel = 3'(i);
      irq_any = 1'b1;
    end
  end
end

assign brk_take = brk_enable && brk_req && !in_break;

////////////////////////////////////////////////////////////////////////////
// sequencing of interrupt entry and low-power modes
always_ff @(posedge mclk) begin
  if (!rstn) begin
    state_reg      <= crf_pkg::CRF_ST_RUN;
    stab_reg       <= 16'h0000;
    vec_fetch_addr <= crf_pkg::VEC_RESET;
    in_break       <= 1'b0;
  end else begin
    case (state_reg)
      crf_pkg::CRF_ST_RUN: begin
        if (instr_done && brk_take) begin
          state_reg      <= crf_pkg::CRF_ST_STACK;
          in_break       <= 1'b1;
          vec_fetch_addr <= monitor_mode ? crf_pkg::VEC_SWI_MON : crf_pkg::VEC_SWI;
        end else if (instr_done && irq_any && !mask) begin
          state_reg      <= crf_pkg::CRF_ST_STACK;
          vec_fetch_addr <= irq_vec_addr[irq_sel];
        end else if (wait_instr) begin
          state_reg <= crf_pkg::CRF_ST_WAIT;
        end else if (stop_instr) begin
          state_reg <= crf_pkg::CRF_ST_STOP;
        end
        if (return_from_irq_instr && in_break && !brk_req) begin
          in_break <= 1'b0;
        end
      end
      crf_pkg::CRF_ST_WAIT, crf_pkg::CRF_ST_STOP: begin
        if (irq_any) begin
          vec_fetch_addr <= irq_vec_addr[irq_sel];
          stab_reg       <= crf_pkg::OSC_STAB_CNT;
          state_reg      <= (state_reg == crf_pkg::CRF_ST_STOP)
                            ? crf_pkg::CRF_ST_STAB : crf_pkg::CRF_ST_STACK;
        end
      end
      crf_pkg::CRF_ST_STAB: begin
        stab_reg <= stab_reg - 16'h0001;
        if (stab_reg == 16'h0001) state_reg <= crf_pkg::CRF_ST_STACK;
      end
      crf_pkg::CRF_ST_STACK: begin
        if (stack_done) state_reg <= crf_pkg::CRF_ST_VEC;
      end
      crf_pkg::CRF_ST_VEC: begin
        if (vec_valid) state_reg <= crf_pkg::CRF_ST_RUN;
      end
      default: state_reg <= crf_pkg::CRF_ST_RUN;
    endcase
  end
end

always_ff @(posedge mclk) begin
  if (!rstn) begin
    cpu_clk_en    <= 1'b1;
    irq_stack_req <= 1'b0;
    vec_fetch_req <= 1'b0;
  end else begin
    cpu_clk_en    <= (state_reg != crf_pkg::CRF_ST_WAIT) && (state_reg != crf_pkg::CRF_ST_STOP)
                  && (state_reg != crf_pkg::CRF_ST_STAB) && !wait_instr && !stop_instr;
    // stacking excludes the index high byte
    irq_stack_req <= (state_reg == crf_pkg::CRF_ST_STACK) && !stack_done;
    vec_fetch_req <= (state_reg == crf_pkg::CRF_ST_VEC && !vec_valid)
                  || (pc_boot_reg && !vec_valid);
  end
end

////////////////////////////////////////////////////////////////////////////
// program pointer
always_ff @(posedge mclk) begin
  if (!rstn) begin
    pc_reg      <= 16'h0000;
    pc_boot_reg <= 1'b1;
  end else if (pc_boot_reg) begin
    if (vec_valid) begin
      pc_reg      <= vec_data;
      pc_boot_reg <= 1'b0;
    end
  end else if (state_reg == crf_pkg::CRF_ST_VEC && vec_valid) begin
    pc_reg <= vec_data;
  end else if (jump) begin
    pc_reg <= jump_addr;
  end else if (reg_wr && reg_addr == crf_pkg::ADR_PC_LO) begin
    pc_reg[7:0] <= reg_wdata;
  end else if (reg_wr && reg_addr == crf_pkg::ADR_PC_HI) begin
    pc_reg[15:8] <= reg_wdata;
  end else if (fetch) begin
    pc_reg <= pc_reg + 16'h0001;
  end
end

////////////////////////////////////////////////////////////////////////////
// condition flags
always_ff @(posedge mclk) begin
  if (!rstn) begin
    flags_reg <= crf_pkg::FLAGS_RESET;
  end else begin
    if (alu_act) begin
      flags_reg[crf_pkg::FLG_N] <= res[7];
      flags_reg[crf_pkg::FLG_Z] <= (res == 8'h00);
      if (alu_op != crf_pkg::CRF_OP_AND && alu_op != crf_pkg::CRF_OP_OR
          && alu_op != crf_pkg::CRF_OP_EOR && alu_op != crf_pkg::CRF_OP_LDA) begin
        flags_reg[crf_pkg::FLG_C] <= res_c;
        flags_reg[crf_pkg::FLG_V] <= res_v;
      end else begin
        flags_reg[crf_pkg::FLG_V] <= 1'b0;
      end
      if (alu_op == crf_pkg::CRF_OP_ADD || alu_op == crf_pkg::CRF_OP_ADC) begin
        flags_reg[crf_pkg::FLG_H] <= half_sum[4];
      end
    end
    if (reg_wr && reg_addr == crf_pkg::ADR_FLAGS) begin
      flags_reg <= reg_wdata | crf_pkg::FLAGS_FIXED;
    end
    if (return_from_irq_instr) begin
      flags_reg <= stacked_flags | crf_pkg::FLAGS_FIXED;
    end else if (state_reg == crf_pkg::CRF_ST_STACK && stack_done) begin
      flags_reg[crf_pkg::FLG_I] <= 1'b1;
    end else if (clear_mask_instr || wait_instr || stop_instr) begin
      flags_reg[crf_pkg::FLG_I] <= 1'b0;
    end else if (set_mask_instr) begin
      flags_reg[crf_pkg::FLG_I] <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// read port and outputs
always_ff @(posedge mclk) begin
  if (!rstn) begin
    reg_rdata <= 8'h00;
  end else if (reg_rd) begin
    case (reg_addr)
      crf_pkg::ADR_ACC:    reg_rdata <= acc_reg;
      crf_pkg::ADR_IDX_LO: reg_rdata <= idx_reg[7:0];
      crf_pkg::ADR_IDX_HI: reg_rdata <= idx_reg[15:8];
      crf_pkg::ADR_SP_LO:  reg_rdata <= sp_reg[7:0];
      crf_pkg::ADR_SP_HI:  reg_rdata <= sp_reg[15:8];
      crf_pkg::ADR_PC_LO:  reg_rdata <= pc_reg[7:0];
      crf_pkg::ADR_PC_HI:  reg_rdata <= pc_reg[15:8];
      default:             reg_rdata <= flags_reg | crf_pkg::FLAGS_FIXED;
    endcase
  end else begin
    reg_rdata <= 8'h00;
  end
end

always_ff @(posedge mclk) begin
  if (!rstn) begin
    index_addr      <= 16'h0000;
    stack_ptr       <= crf_pkg::SP_RESET;
    instr_pointer   <= 16'h0000;
    condition_flags <= crf_pkg::FLAGS_RESET;
  end else begin
    index_addr      <= idx_reg;
    stack_ptr       <= sp_reg;
    instr_pointer   <= pc_reg;
    condition_flags <= flags_reg | crf_pkg::FLAGS_FIXED;
  end
end

////////////////////////////////////////////////////////////////////////////
// checks
sp_reset_val_a: assert property (@(posedge mclk) !rstn |=> sp_reg == 16'h00FF)
  else $error("stack pointer not 00FF after reset");
sp_low_set_a: assert property (@(posedge mclk) disable iff (!rstn)
  reset_stack_low_instr |=> sp_reg == {$past(sp_reg[15:8]), 8'hFF})
  else $error("reset stack low failed");
sp_push_dec_a: assert property (@(posedge mclk) disable iff (!rstn)
  push && !reset_stack_low_instr && !reg_wr |=> sp_reg == $past(sp_reg) - 16'h0001)
  else $error("push did not decrement stack pointer");
flags_fixed_a: assert property (@(posedge mclk) disable iff (!rstn)
  flags_reg[6:5] == 2'b11)
  else $error("fixed flag bits not one");
mask_reset_a: assert property (@(posedge mclk) !rstn |=> mask)
  else $error("mask not set after reset");
mask_blocks_a: assert property (@(posedge mclk) disable iff (!rstn)
  state_reg == crf_pkg::CRF_ST_RUN && mask && !brk_take |=>
  state_reg != crf_pkg::CRF_ST_STACK)
  else $error("masked interrupt taken");
entry_order_a: assert property (@(posedge mclk) disable iff (!rstn)
  state_reg == crf_pkg::CRF_ST_STACK && stack_done && !return_from_irq_instr |=>
  mask && state_reg == crf_pkg::CRF_ST_VEC)
  else $error("mask not set before vector fetch");
zero_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
  alu_act && !reg_wr && !return_from_irq_instr |=>
  flags_reg[crf_pkg::FLG_Z] == ($past(res) == 8'h00))
  else $error("zero flag wrong");
stop_stab_a: assert property (@(posedge mclk) disable iff (!rstn)
  state_reg == crf_pkg::CRF_ST_STOP && irq_any |=> !cpu_clk_en [*4])
  else $error("clock restarted before stabilization");

endmodule : crf_core

// ### verif/crf_seq_model.sv
// crf_seq_model: sequencer and memory side facing crf_core
// assumes: crf_core raises irq_stack_req and vec_fetch_req as levels
`timescale 1ns/1ns
module crf_seq_model #(
  parameter int STACK_BYTES = 5,
  parameter int VEC_LAT     = 3
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // requests from core
  input  wire logic        irq_stack_req,
  input  wire logic        vec_fetch_req,
  input  wire logic [15:0] vec_fetch_addr,
  // answers to core
  output logic             push,
  output logic             stack_done,
  output logic             vec_valid,
  output logic      [15:0] vec_data
);
  logic [3:0] stk_cnt;
  logic [3:0] vec_cnt;
  ////////////////////////////////////////////////////////////////
  // stacking: pc lo, pc hi, index lo, acc, flags, never index hi
  always_ff @(posedge mclk) begin
    push       <= 1'b0;
    stack_done <= 1'b0;
    if (!rstn || !irq_stack_req) begin
      stk_cnt <= 4'h0;
    end else if (stk_cnt < 4'(STACK_BYTES)) begin
      push    <= 1'b1;
      stk_cnt <= stk_cnt + 4'h1;
    end else if (stk_cnt == 4'(STACK_BYTES)) begin
      stack_done <= 1'b1;
      stk_cnt    <= stk_cnt + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////
  // vector word read, scrambled outside the valid cycle
  always_ff @(posedge mclk) begin
    vec_valid <= 1'b0;
    vec_data  <= ~vec_data;
    if (!rstn || !vec_fetch_req) begin
      vec_cnt <= 4'h0;
    end else if (vec_cnt < 4'(VEC_LAT)) begin
      vec_cnt <= vec_cnt + 4'h1;
    end else if (vec_cnt == 4'(VEC_LAT)) begin
      vec_valid <= 1'b1;
      vec_data  <= vec_fetch_addr ^ 16'h5A5A;
      vec_cnt   <= vec_cnt + 4'h1;
    end
  end
endmodule : crf_seq_model

// ### verif/tb_cpu_registers_and_condition_codes.sv
// tb_cpu_registers_and_condition_codes: scenario bench for crf_core
// assumes: crf_seq_model returns vector words as address xor 5A5A
`timescale 1ns/1ns
module tb_cpu_registers_and_condition_codes;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  crf_pkg::crf_alu_e alu_op = crf_pkg::CRF_OP_NONE;
  logic [7:0] alu_operand = 8'h00;
  logic [10:0] st = 11'h000;
  logic [15:0] jump_addr = 16'h0000;
  logic [7:0] stacked_flags = 8'h60;
  logic [7:0] irq_req = 8'h00;
  logic [15:0] irq_vec [8];
  logic brk_enable = 1'b0;
  logic brk_req = 1'b0;
  logic monitor_mode = 1'b0;
  logic vec_valid, m_push, stack_done, cpu_clk_en, irq_stack_req, vec_fetch_req, in_break;
  logic [15:0] vec_data, index_addr, stack_ptr, instr_pointer, vec_fetch_addr;
  logic [7:0] condition_flags;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;

  always #4 mclk = ~mclk;
  initial for (int i = 0; i < 8; i++) irq_vec[i] = 16'hE000 + 16'(i * 4);

  crf_core DUT (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alu_op(alu_op),
    .alu_operand(alu_operand), .fetch(st[0]), .jump(st[1]), .jump_addr(jump_addr),
    .push(st[2] | m_push), .pull(st[3]), .reset_stack_low_instr(st[4]),
    .clear_mask_instr(st[5]), .set_mask_instr(st[6]), .return_from_irq_instr(st[7]),
    .stacked_flags(stacked_flags), .wait_instr(st[8]), .stop_instr(st[9]),
    .instr_done(st[10]), .stack_done(stack_done), .irq_req(irq_req), .irq_vec_addr(irq_vec),
    .brk_enable(brk_enable), .brk_req(brk_req), .monitor_mode(monitor_mode),
    .vec_valid(vec_valid), .vec_data(vec_data), .index_addr(index_addr),
    .stack_ptr(stack_ptr), .instr_pointer(instr_pointer), .condition_flags(condition_flags),
    .cpu_clk_en(cpu_clk_en), .irq_stack_req(irq_stack_req), .vec_fetch_req(vec_fetch_req),
    .vec_fetch_addr(vec_fetch_addr), .in_break(in_break));

  crf_seq_model #(.STACK_BYTES(5), .VEC_LAT(3)) u_seq (.mclk(mclk), .rstn(rstn),
    .irq_stack_req(irq_stack_req), .vec_fetch_req(vec_fetch_req),
    .vec_fetch_addr(vec_fetch_addr), .push(m_push), .stack_done(stack_done),
    .vec_valid(vec_valid), .vec_data(vec_data));

  ////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task results;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    @(posedge mclk) reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge mclk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task rd16(input logic [2:0] lo, output logic [15:0] d);
    rd(lo, d[7:0]);
    rd(lo + 3'h1, d[15:8]);
  endtask : rd16

  task strobe(input int b);
    @(posedge mclk) st <= 11'(1 << b);
    @(posedge mclk) st <= 11'h000;
  endtask : strobe

  function automatic logic sig(input int w);
    case (w)
      0: return vec_fetch_req;
      1: return !vec_fetch_req;
      default: return cpu_clk_en;
    endcase
  endfunction : sig

  task wait_for(input int w, output int n);
    n = 0;
    while (sig(w) !== 1'b1 && n < 200) begin
      @(posedge mclk);
      #1 n++;
    end
    if (n >= 200) chk(16'h0, 16'h1, "handshake never came");
  endtask : wait_for

  task alu(input logic [7:0] a, input crf_pkg::crf_alu_e op, input logic [7:0] b,
           input logic [7:0] r, input logic [7:0] fe, input logic [7:0] fm);
    logic [7:0] d;
    wr(crf_pkg::ADR_ACC, a);
    @(posedge mclk) begin alu_op <= op; alu_operand <= b; end
    @(posedge mclk) alu_op <= crf_pkg::CRF_OP_NONE;
    rd(crf_pkg::ADR_ACC, d);
    chk(d, r, "alu result");
    rd(crf_pkg::ADR_FLAGS, d);
    chk(d & fm, fe, "alu flags");
  endtask : alu

  ////////////////////////////////////////////////////////////////
  task t_reset_and_regs;
    logic [15:0] v;
    logic [7:0] f;
    rd16(crf_pkg::ADR_SP_LO, v);
    chk(v, 16'h00FF, "stack after reset");
    rd(crf_pkg::ADR_FLAGS, f);
    chk(f, 8'h68, "flags after reset");
    rd16(crf_pkg::ADR_PC_LO, v);
    chk(v, 16'hFFFE ^ 16'h5A5A, "pc from reset vector");
    wr(crf_pkg::ADR_FLAGS, 8'h00);
    rd(crf_pkg::ADR_FLAGS, f);
    chk(f, 8'h60, "fixed flag bits");
    chk(condition_flags, 8'h60, "flags mirror");
    wr(crf_pkg::ADR_IDX_LO, 8'h34);
    wr(crf_pkg::ADR_IDX_HI, 8'h12);
    repeat (2) @(posedge mclk);
    #1 chk(index_addr, 16'h1234, "index pair");
  endtask : t_reset_and_regs

  task t_alu;
    alu(8'h7F, crf_pkg::CRF_OP_ADD, 8'h01, 8'h80, 8'hF4, 8'hF7);
    alu(8'hFF, crf_pkg::CRF_OP_ADD, 8'h01, 8'h00, 8'h73, 8'hF7);
    alu(8'h00, crf_pkg::CRF_OP_SUB, 8'h01, 8'hFF, 8'h65, 8'hE7);
    alu(8'hF0, crf_pkg::CRF_OP_AND, 8'h0F, 8'h00, 8'h62, 8'hE6);
    alu(8'h09, crf_pkg::CRF_OP_ADC, 8'h08, 8'h12, 8'h70, 8'hF7);
    alu(8'h12, crf_pkg::CRF_OP_DAA, 8'h00, 8'h18, 8'h70, 8'hF7);
    alu(8'h81, crf_pkg::CRF_OP_ASL, 8'h00, 8'h02, 8'hF1, 8'hF7);
  endtask : t_alu

  task t_stack_pc;
    logic [15:0] v;
    logic [15:0] p;
    repeat (3) strobe(2);
    strobe(3);
    rd16(crf_pkg::ADR_SP_LO, v);
    chk(v, 16'h00FD, "push and pull");
    wr(crf_pkg::ADR_SP_HI, 8'h12);
    strobe(4);
    rd16(crf_pkg::ADR_SP_LO, v);
    chk(v, 16'h12FF, "stack low reset");
    chk(stack_ptr, 16'h12FF, "stack mirror");
    rd16(crf_pkg::ADR_PC_LO, p);
    repeat (3) strobe(0);
    rd16(crf_pkg::ADR_PC_LO, v);
    chk(v, p + 16'h0003, "fetch advance");
    jump_addr <= 16'h1234;
    strobe(1);
    rd16(crf_pkg::ADR_PC_LO, v);
    chk(v, 16'h1234, "jump load");
    chk(instr_pointer, 16'h1234, "pc mirror");
  endtask : t_stack_pc

  task t_irq;
    logic [15:0] s0, v;
    logic [7:0] f;
    int n;
    strobe(6);
    rd16(crf_pkg::ADR_SP_LO, s0);
    @(posedge mclk) irq_req <= 8'h06;
    strobe(10);
    repeat (10) @(posedge mclk);
    #1 chk(irq_stack_req, 1'b0, "masked request taken");
    strobe(5);
    strobe(10);
    wait_for(0, n);
    chk(vec_fetch_addr, irq_vec[1], "priority vector");
    rd(crf_pkg::ADR_FLAGS, f);
    chk(f[3], 1'b1, "mask before vector");
    wait_for(1, n);
    @(posedge mclk) irq_req <= 8'h00;
    rd16(crf_pkg::ADR_SP_LO, v);
    chk(v, s0 - 16'h0005, "stacked bytes");
    rd16(crf_pkg::ADR_PC_LO, v);
    chk(v, irq_vec[1] ^ 16'h5A5A, "pc from vector");
    strobe(7);
    rd(crf_pkg::ADR_FLAGS, f);
    chk(f[3], 1'b0, "mask restored");
  endtask : t_irq

  task t_break;
    int n;
    for (int m = 0; m < 2; m++) begin
      @(posedge mclk) begin brk_enable <= 1'b1; brk_req <= 1'b1; monitor_mode <= m[0]; end
      strobe(10);
      wait_for(0, n);
      chk(vec_fetch_addr, m ? crf_pkg::VEC_SWI_MON : crf_pkg::VEC_SWI, "break vector");
      wait_for(1, n);
      chk(in_break, 1'b1, "in break");
      strobe(7);
      repeat (2) @(posedge mclk);
      #1 chk(in_break, 1'b1, "break held by request");
      @(posedge mclk) brk_req <= 1'b0;
      strobe(7);
      repeat (2) @(posedge mclk);
      #1 chk(in_break, 1'b0, "break ended");
    end
    @(posedge mclk) brk_enable <= 1'b0;
  endtask : t_break

  task t_low_power(input int b);
    logic [7:0] f;
    int n;
    strobe(6);
    strobe(b);
    repeat (2) @(posedge mclk);
    #1 chk(cpu_clk_en, 1'b0, "clock stopped");
    rd(crf_pkg::ADR_FLAGS, f);
    chk(f[3], 1'b0, "mask cleared");
    @(posedge mclk) irq_req <= 8'h80;
    wait_for(2, n);
    @(posedge mclk) irq_req <= 8'h00;
    if (b == 9) chk(16'(n >= crf_pkg::OSC_STAB_CYC), 16'h1, "stabilization wait");
    rd(crf_pkg::ADR_FLAGS, f);
    chk(f[3], 1'b0, "mask clear after wake");
    // let the wake interrupt finish its entry, then return from it
    wait_for(0, n);
    wait_for(1, n);
    strobe(7);
  endtask : t_low_power

  ////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      results();
    end
  end

  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    repeat (10) @(posedge mclk);
    t_reset_and_regs();
    t_alu();
    t_stack_pc();
    t_irq();
    t_break();
    t_low_power(8);
    t_low_power(9);
    results();
  end
endmodule : tb_cpu_registers_and_condition_codes
